/* rtl/timer_pwm_cfg.svh */
// Constants for the timer compare and PWM channel block.
`ifndef TIMER_PWM_CFG_SVH
`define TIMER_PWM_CFG_SVH

// Clock source select codes.
`define CLK_SRC_OFF   2'b00
`define CLK_SRC_BUS   2'b01
`define CLK_SRC_FIXED 2'b10
`define CLK_SRC_EXT   2'b11

// Field positions in the main status/control byte.
`define SC_FLAG_BIT   7
`define SC_IE_BIT     6
`define SC_CENTER_BIT 5
`define SC_CLK_HI     4
`define SC_CLK_LO     3

// Field positions in the channel status/control byte.
`define CSC_MSB_BIT   5
`define CSC_MSA_BIT   4
`define CSC_ELSB_BIT  3
`define CSC_ELSA_BIT  2

// Counter values with a fixed meaning.
`define CNT_ZERO      16'h0000
`define CNT_FREE_TERM 16'hFFFF
`define VAL_SIGN_BIT  15

// Reset value of every control byte.
`define CTRL_RESET    8'h00

`endif

/* rtl/timer_pwm_pkg.sv */
// Types shared by the timer compare and PWM channel block.
package timer_pwm_pkg;

  // Main control fields kept by the block.
  typedef struct packed {
    logic [1:0] clock_source_select;
    logic       center_align_select;
    logic       counter_wrap_irq_enable;
  } timer_ctrl_t;

  // Channel control fields kept by the block.
  typedef struct packed {
    logic channel_event_irq_enable;
    logic channel_mode_select_b;
    logic channel_mode_select_a;
    logic edge_level_select_b;
    logic edge_level_select_a;
  } chan_ctrl_t;

  // One byte write from software, with a strobe for each target byte.
  typedef struct packed {
    logic       timer_sc;
    logic       mod_high;
    logic       mod_low;
    logic       chan_sc;
    logic       val_high;
    logic       val_low;
    logic       count_clear;
    logic [7:0] data;
  } byte_write_t;

  // Software reads of the two flag bytes.
  typedef struct packed {
    logic wrap_flag_read;
    logic chan_flag_read;
  } flag_read_t;

  // Direction in which the counter reached its present value.
  typedef enum logic {DIR_UP, DIR_DOWN} count_dir_t;

  // Operating mode of the channel.
  typedef enum logic [1:0] {MODE_CAPTURE, MODE_COMPARE, MODE_EDGE_PWM, MODE_CENTER_PWM} chan_mode_t;

  // Progress of a two-byte coherent write.
  typedef enum logic [1:0] {COH_EMPTY, COH_HIGH, COH_LOW, COH_FULL} coh_state_t;

endpackage : timer_pwm_pkg

/* rtl/flag_two_step.sv */
// Event flag cleared by a read while set followed by a write of zero.
`timescale 1ns/1ps
module flag_two_step (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic set_event,
  input  wire logic read_seen,
  input  wire logic clear_write,
  output logic      flag_r
);

  logic armed_r;  // A read saw the flag set and a clear may follow.

  // Arms on a read of the set flag; a new event or the clear write disarms it.
  always_ff @(posedge clock) begin
    if (reset) begin
      armed_r <= 1'b0;
    end else if (set_event || clear_write) begin
      armed_r <= 1'b0;  // R20
    end else if (read_seen && flag_r) begin
      armed_r <= 1'b1;
    end
  end

  // The event always wins over a clear in the same cycle.
  always_ff @(posedge clock) begin
    if (reset) begin
      flag_r <= 1'b0;
    end else if (set_event) begin
      flag_r <= 1'b1;
    end else if (clear_write && armed_r) begin
      flag_r <= 1'b0;  // R20
    end
  end

  a_set_wins_clear: assert property (@(posedge clock) disable iff (reset) set_event |=> flag_r)  // R20
    else $error("flag lost an event");
  a_clear_needs_arm: assert property (@(posedge clock) disable iff (reset)
      (flag_r && clear_write && !armed_r && !set_event) |=> flag_r)  // R20
    else $error("flag cleared without a prior read");

endmodule : flag_two_step

/* rtl/pwm_counter.sv */
// Main timer counter with up and up/down counting and its event pulses.
`timescale 1ns/1ps
module pwm_counter
  import timer_pwm_pkg::*;
#(
  parameter int COUNT_W = 16
) (
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire logic               tick,
  input  wire logic               center,
  input  wire logic               clear,
  input  wire logic [COUNT_W-1:0] modulus,
  output logic      [COUNT_W-1:0] count_r,
  output count_dir_t              dir_r,
  output logic                    moved_r,
  output logic                    wrap_r,
  output logic                    load_r
);

  // Refuses widths too narrow for the turn-around logic.
  if (COUNT_W < 2) begin : g_width_check
    $error("COUNT_W must be at least 2");
  end

  logic [COUNT_W-1:0] term;  // Terminal count: modulus, or all ones when free running.
  assign term = (modulus == '0) ? '1 : modulus;

  // Steps the count on each tick; in center mode it turns at both ends.
  always_ff @(posedge clock) begin
    if (reset || clear) begin
      count_r <= '0;
      dir_r   <= DIR_UP;
    end else if (tick) begin
      if (!center) begin
        count_r <= (count_r == term) ? '0 : COUNT_W'(count_r + 1'b1);
        dir_r   <= DIR_UP;
      end else if (dir_r == DIR_UP) begin
        if (count_r == term) begin
          count_r <= COUNT_W'(count_r - 1'b1);  // R21
          dir_r   <= DIR_DOWN;
        end else begin
          count_r <= COUNT_W'(count_r + 1'b1);
        end
      end else if (count_r == '0) begin
        count_r <= COUNT_W'(count_r + 1'b1);  // R21
        dir_r   <= DIR_UP;
      end else begin
        count_r <= COUNT_W'(count_r - 1'b1);
      end
    end
  end

  // Pulses that line up with the cycle in which the new count is shown.
  always_ff @(posedge clock) begin
    if (reset || clear) begin
      moved_r <= 1'b0;
      wrap_r  <= 1'b0;
      load_r  <= 1'b0;
    end else begin
      moved_r <= tick;
      wrap_r  <= tick && (count_r == term) && (!center || dir_r == DIR_UP);  // R16
      load_r  <= tick && (dir_r == DIR_UP) && (count_r == COUNT_W'(term - 1'b1));  // R8
    end
  end

  a_wrap_to_zero: assert property (@(posedge clock) disable iff (reset) (wrap_r && !$past(center)) |-> count_r == '0)  // R16
    else $error("wrap pulse without a zero count");
  a_center_turn_down: assert property (@(posedge clock) disable iff (reset || clear)
      (tick && center && dir_r == DIR_UP && count_r == term) |=> (dir_r == DIR_DOWN && wrap_r))  // R21
    else $error("center counter did not turn at the terminal count");

endmodule : pwm_counter

/* rtl/timer_channel_compare_pwm.sv */
// Timer with one channel for capture, output compare, edge PWM and center PWM.
`timescale 1ns/1ps
`include "timer_pwm_cfg.svh"

// Function
// R1: Compare match sets, clears or toggles pin.
// R2: Compare value loads on next counter change.
// R3: Channel control write restarts value byte pairing.
// R4: Compare match sets the channel event flag.
// R5: Edge PWM period is modulus plus one.
// R6: Edge PWM: wrap drives active, match inactive.
// R7: Zero gives 0%, above modulus gives 100%.
// R8: PWM values load at modulus minus one.
// R9: Center PWM counts up then down.
// R10: Center PWM: zero or negative gives 0%.
// R11: Center PWM: up match low, down high.
// R12: Software keeps center modulus in 1..0x7FFF.
// R13: Main control write restarts modulus byte pairing.
// R14: Software uses center PWM only in center mode.
// R15: Reset clears controls and releases the pin.
// R16: Wrap flag sets at the terminal count.
// R17: Channel flag on capture edge or match.
// R18: Interrupt request high for enabled set flags.
// R19: Clock source codes: off, bus, fixed, external.
// R20: Flags clear by read then zero write.
// R21: Center counter ends last one period each.
// R22: Polarity bit inverts center PWM output.
module timer_channel_compare_pwm
  import timer_pwm_pkg::*;
(
  input  wire logic                      clock,
  input  wire logic                      reset,
  input  wire timer_pwm_pkg::byte_write_t byte_write,
  input  wire timer_pwm_pkg::flag_read_t  flag_read,
  input  wire logic                      fixed_clock_tick,
  input  wire logic                      ext_clock_in,
  input  wire logic                      chan_pin_in,
  output logic                           chan_pin_out,
  output logic                           chan_pin_oe_n,
  output logic [7:0]                     timer_status_control,
  output logic [7:0]                     channel_status_control,
  output logic [15:0]                    counter_value,
  output logic [15:0]                    channel_compare_value,
  output logic [15:0]                    counter_modulus_value,
  output logic                           irq_request
);

  import timer_pwm_pkg::*;

  timer_ctrl_t ctrl_r;             // Main control fields.
  chan_ctrl_t  chan_ctrl_r;        // Channel control fields.
  logic [15:0] mod_buf_r;          // Modulus bytes waiting for their partner.
  coh_state_t  mod_coh_r;          // Modulus byte pairing progress.
  logic [15:0] val_buf_r;          // Channel value bytes waiting to load.
  coh_state_t  val_coh_r;          // Channel value byte pairing progress.
  logic [15:0] modulus_r;          // Modulus in force.
  logic [15:0] val_r;              // Channel value in force.
  logic [2:0]  ext_sync_r;         // External clock synchroniser and edge history.
  logic [2:0]  pin_sync_r;         // Channel pin synchroniser and edge history.
  logic        pin_r;              // Channel pin level.
  logic        oe_n_r;             // Channel pin output enable, low while driving.
  logic        irq_r;              // Registered interrupt request.
  logic        tick;               // Counter advance enable for this cycle.
  logic [15:0] count;              // Current counter value.
  count_dir_t  dir;                // Direction in which the count was reached.
  logic        moved;              // The count changed in the previous cycle.
  logic        wrap;               // Terminal count was just left.
  logic        load_pt;            // Counter just went from terminal minus one.
  logic        wrap_flag;          // Counter wrap event flag.
  logic        chan_flag;          // Channel event flag.
  logic        match;              // Counter newly equals the channel value.
  logic        cap_edge;           // Selected capture edge seen on the pin.
  logic        val_second;         // This write completes a channel value pair.
  logic        val_ready;          // A complete channel value is waiting.
  logic        val_load;           // Buffered channel value loads this cycle.
  logic        active_lvl;         // PWM active level set by the polarity bit.
  chan_mode_t  mode;               // Decoded channel mode.

  // Decodes the channel mode from the module and channel mode bits.
  function automatic chan_mode_t decode_mode(input logic center, input chan_ctrl_t cc);
    if (center) begin
      decode_mode = MODE_CENTER_PWM;
    end else if (cc.channel_mode_select_b) begin
      decode_mode = MODE_EDGE_PWM;
    end else if (cc.channel_mode_select_a) begin
      decode_mode = MODE_COMPARE;
    end else begin
      decode_mode = MODE_CAPTURE;
    end
  endfunction : decode_mode

  // Advances a byte pairing state with a high or a low byte.
  function automatic coh_state_t pair_step(input coh_state_t st, input logic high);
    if (st == COH_FULL) begin
      pair_step = high ? COH_HIGH : COH_LOW;
    end else if ((high && st == COH_LOW) || (!high && st == COH_HIGH)) begin
      pair_step = COH_FULL;
    end else begin
      pair_step = high ? COH_HIGH : COH_LOW;
    end
  endfunction : pair_step

  assign mode       = decode_mode(ctrl_r.center_align_select, chan_ctrl_r);
  assign active_lvl = ~chan_ctrl_r.edge_level_select_a;
  assign match      = moved && (count == val_r);
  assign cap_edge   = (chan_ctrl_r.edge_level_select_a && pin_sync_r[1] && !pin_sync_r[2])
                   || (chan_ctrl_r.edge_level_select_b && !pin_sync_r[1] && pin_sync_r[2]);

  // Chooses the counter advance from the clock source field.
  always_comb begin
    case (ctrl_r.clock_source_select)
      `CLK_SRC_BUS:   tick = 1'b1;  // R19
      `CLK_SRC_FIXED: tick = fixed_clock_tick;
      `CLK_SRC_EXT:   tick = ext_sync_r[1] && !ext_sync_r[2];
      default:        tick = 1'b0;
    endcase
  end

  // Brings the external clock and channel pin into the clock domain.
  always_ff @(posedge clock) begin
    if (reset) begin
      ext_sync_r <= 3'b000;
      pin_sync_r <= 3'b000;
    end else begin
      ext_sync_r <= {ext_sync_r[1:0], ext_clock_in};
      pin_sync_r <= {pin_sync_r[1:0], chan_pin_in};
    end
  end

  // Main control byte; reset stops the counter and every mode bit.
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_r <= timer_ctrl_t'(`CTRL_RESET);  // R15
    end else if (byte_write.timer_sc) begin
      ctrl_r.counter_wrap_irq_enable <= byte_write.data[`SC_IE_BIT];
      ctrl_r.center_align_select     <= byte_write.data[`SC_CENTER_BIT];
      ctrl_r.clock_source_select     <= byte_write.data[`SC_CLK_HI:`SC_CLK_LO];
    end
  end

  // Channel control byte; reset returns the channel to capture with the pin released.
  always_ff @(posedge clock) begin
    if (reset) begin
      chan_ctrl_r <= chan_ctrl_t'(`CTRL_RESET);  // R15
    end else if (byte_write.chan_sc) begin
      chan_ctrl_r.channel_event_irq_enable <= byte_write.data[`SC_IE_BIT];
      chan_ctrl_r.channel_mode_select_b    <= byte_write.data[`CSC_MSB_BIT];
      chan_ctrl_r.channel_mode_select_a    <= byte_write.data[`CSC_MSA_BIT];
      chan_ctrl_r.edge_level_select_b      <= byte_write.data[`CSC_ELSB_BIT];
      chan_ctrl_r.edge_level_select_a      <= byte_write.data[`CSC_ELSA_BIT];
    end
  end

  // Modulus bytes go to a buffer and take effect once both halves are in.
  always_ff @(posedge clock) begin
    if (reset) begin
      mod_buf_r <= `CNT_ZERO;
      mod_coh_r <= COH_EMPTY;
      modulus_r <= `CNT_ZERO;
    end else if (byte_write.timer_sc) begin
      mod_coh_r <= COH_EMPTY;  // R13
    end else if (byte_write.mod_high || byte_write.mod_low) begin
      mod_coh_r <= pair_step(mod_coh_r, byte_write.mod_high);  // R13
      if (byte_write.mod_high) begin
        mod_buf_r[15:8] <= byte_write.data;
      end else begin
        mod_buf_r[7:0] <= byte_write.data;
      end
      if (pair_step(mod_coh_r, byte_write.mod_high) == COH_FULL) begin
        modulus_r <= byte_write.mod_high ? {byte_write.data, mod_buf_r[7:0]} : {mod_buf_r[15:8], byte_write.data};
      end
    end
  end

  assign val_second = (byte_write.val_high || byte_write.val_low) && mode != MODE_CAPTURE
                   && pair_step(val_coh_r, byte_write.val_high) == COH_FULL;
  assign val_ready  = val_coh_r == COH_FULL;

  // Picks the moment a complete buffered value takes effect.
  always_comb begin
    if (ctrl_r.clock_source_select == `CLK_SRC_OFF) begin
      val_load = val_ready;  // R2 R8
    end else if (mode == MODE_COMPARE) begin
      val_load = val_ready && moved;  // R2
    end else begin
      val_load = val_ready && load_pt && mode != MODE_CAPTURE;  // R8
    end
  end

  // Channel value byte buffer; a channel control write drops any half-written pair.
  always_ff @(posedge clock) begin
    if (reset) begin
      val_buf_r <= `CNT_ZERO;
      val_coh_r <= COH_EMPTY;
    end else if (byte_write.chan_sc) begin
      val_coh_r <= COH_EMPTY;  // R3
    end else if ((byte_write.val_high || byte_write.val_low) && mode != MODE_CAPTURE) begin
      val_coh_r <= pair_step(val_coh_r, byte_write.val_high);
      if (byte_write.val_high) begin
        val_buf_r[15:8] <= byte_write.data;
      end else begin
        val_buf_r[7:0] <= byte_write.data;
      end
    end else if (val_load) begin
      val_coh_r <= COH_EMPTY;
    end
  end

  // Channel value in force: capture latch, or load from the buffer.
  always_ff @(posedge clock) begin
    if (reset) begin
      val_r <= `CNT_ZERO;
    end else if (mode == MODE_CAPTURE && cap_edge) begin
      val_r <= count;  // R17
    end else if (val_load && !byte_write.chan_sc && !val_second) begin
      val_r <= val_buf_r;  // R2 R8
    end
  end

  // Drives the channel pin for compare and both PWM modes.
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_r  <= 1'b0;
      oe_n_r <= 1'b1;  // R15
    end else begin
      oe_n_r <= (mode == MODE_CAPTURE) || !(chan_ctrl_r.edge_level_select_a || chan_ctrl_r.edge_level_select_b);
      case (mode)
        MODE_COMPARE: begin
          if (match) begin
            case ({chan_ctrl_r.edge_level_select_b, chan_ctrl_r.edge_level_select_a})
              2'b01:   pin_r <= ~pin_r;  // R1
              2'b10:   pin_r <= 1'b0;    // R1
              2'b11:   pin_r <= 1'b1;    // R1
              default: pin_r <= pin_r;
            endcase
          end
        end
        MODE_EDGE_PWM: begin
          if (match) begin
            pin_r <= ~active_lvl;  // R6 R7
          end else if (wrap) begin
            pin_r <= active_lvl;   // R5 R6
          end
        end
        MODE_CENTER_PWM: begin
          if (val_r == `CNT_ZERO || val_r[`VAL_SIGN_BIT]) begin
            pin_r <= ~active_lvl;  // R10
          end else if (val_r > modulus_r && modulus_r != `CNT_ZERO) begin
            pin_r <= active_lvl;   // R10
          end else if (match) begin
            pin_r <= (dir == DIR_UP) ? ~active_lvl : active_lvl;  // R11 R22
          end
        end
        default: pin_r <= pin_r;
      endcase
    end
  end

  // Raises the request for each flag whose enable is set.
  always_ff @(posedge clock) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (wrap_flag && ctrl_r.counter_wrap_irq_enable)
            || (chan_flag && chan_ctrl_r.channel_event_irq_enable);  // R18
    end
  end

  // Counter that serves both counting modes.
  pwm_counter #(.COUNT_W(16)) u_counter (
    .clock   (clock),
    .reset   (reset),
    .tick    (tick),
    .center  (ctrl_r.center_align_select),  // R9
    .clear   (byte_write.count_clear),
    .modulus (modulus_r),
    .count_r (count),
    .dir_r   (dir),
    .moved_r (moved),
    .wrap_r  (wrap),
    .load_r  (load_pt)
  );

  // Counter wrap flag.
  flag_two_step u_wrap_flag (
    .clock       (clock),
    .reset       (reset),
    .set_event   (wrap),  // R16
    .read_seen   (flag_read.wrap_flag_read),
    .clear_write (byte_write.timer_sc && !byte_write.data[`SC_FLAG_BIT]),
    .flag_r      (wrap_flag)
  );

  // Channel event flag, set by a capture edge or a match.
  flag_two_step u_chan_flag (
    .clock       (clock),
    .reset       (reset),
    .set_event   ((mode == MODE_CAPTURE) ? cap_edge : match),  // R4 R17
    .read_seen   (flag_read.chan_flag_read),
    .clear_write (byte_write.chan_sc && !byte_write.data[`SC_FLAG_BIT]),
    .flag_r      (chan_flag)
  );

  assign chan_pin_out           = pin_r;
  assign chan_pin_oe_n          = oe_n_r;
  assign irq_request            = irq_r;
  assign counter_value          = count;
  assign channel_compare_value  = val_r;
  assign counter_modulus_value  = modulus_r;
  assign timer_status_control   = {wrap_flag, ctrl_r.counter_wrap_irq_enable, ctrl_r.center_align_select,
                                   ctrl_r.clock_source_select, 3'b000};
  assign channel_status_control = {chan_flag, chan_ctrl_r.channel_event_irq_enable, chan_ctrl_r.channel_mode_select_b,
                                   chan_ctrl_r.channel_mode_select_a, chan_ctrl_r.edge_level_select_b,
                                   chan_ctrl_r.edge_level_select_a, 2'b00};

  a_irq_follows_flags: assert property (@(posedge clock) disable iff (reset)  // R18
      ((wrap_flag && ctrl_r.counter_wrap_irq_enable) || (chan_flag && chan_ctrl_r.channel_event_irq_enable))
      |=> irq_request)
    else $error("interrupt request missing for an enabled flag");
  a_compare_sets_flag: assert property (@(posedge clock) disable iff (reset)  // R4
      (mode == MODE_COMPARE && match) |=> chan_flag)
    else $error("compare match did not set the channel flag");
  a_edge_zero_duty: assert property (@(posedge clock) disable iff (reset)  // R7
      (mode == MODE_EDGE_PWM && wrap && val_r == `CNT_ZERO) |=> chan_pin_out == ~active_lvl)
    else $error("zero channel value did not give 0 percent duty");
  a_edge_wrap_active: assert property (@(posedge clock) disable iff (reset)  // R6
      (mode == MODE_EDGE_PWM && wrap && !match) |=> chan_pin_out == active_lvl)
    else $error("edge PWM wrap did not drive the active level");
  a_center_up_match: assert property (@(posedge clock) disable iff (reset)  // R11
      (mode == MODE_CENTER_PWM && match && dir == DIR_UP && val_r != `CNT_ZERO && !val_r[`VAL_SIGN_BIT]
       && val_r <= modulus_r) |=> chan_pin_out == ~$past(active_lvl))
    else $error("center PWM up match did not drive the inactive level");
  a_clock_off_load: assert property (@(posedge clock) disable iff (reset)  // R2
      (ctrl_r.clock_source_select == `CLK_SRC_OFF && val_second && !byte_write.chan_sc) ##1 !byte_write.chan_sc
      |=> val_r == $past(val_buf_r))
    else $error("value did not load on the second byte with the clock off");
  a_chan_sc_restart: assert property (@(posedge clock) disable iff (reset)  // R3
      byte_write.chan_sc |=> val_coh_r == COH_EMPTY)
    else $error("channel control write did not restart value pairing");
  a_capture_releases: assert property (@(posedge clock) disable iff (reset)  // R15
      mode == MODE_CAPTURE |=> chan_pin_oe_n)
    else $error("pin driven while in capture mode");

endmodule : timer_channel_compare_pwm

/* bench/timer_channel_compare_pwm_tb.sv */
// Self-checking bench for the timer capture, compare, edge PWM and center PWM channel block.
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module timer_channel_compare_pwm_tb;
  import timer_pwm_pkg::*;
  logic        clock = 0;      // Bench clock, 200 MHz.
  logic        reset = 1;      // Synchronous reset, held three cycles.
  byte_write_t bw    = '0;     // Byte write strobes and data.
  flag_read_t  fr    = '0;     // Flag status read pulses.
  logic        pin_in = 0;     // Capture pin input, unused in PWM runs.
  logic        fix_tick = 0;   // Fixed clock enable, never selected here.
  logic        ext_in = 0;     // External clock pin, never selected here.
  logic        pin_out, oe_n, irq;
  logic [7:0]  tsc, csc;
  logic [15:0] cnt, cval, cmod;
  int          num_errors = 0, tests_run = 0;
  int          md, vl, old_md = 0, old_vl = 0, pc, ex, kd;
  bit          run = 0, seen = 0, pin_ok = 0, mp = 0, dn = 0;
  logic [7:0]  csd;            // Channel control byte of the present run.
  timer_channel_compare_pwm uut (.clock(clock), .reset(reset), .byte_write(bw), .flag_read(fr),
    .fixed_clock_tick(fix_tick), .ext_clock_in(ext_in), .chan_pin_in(pin_in), .chan_pin_out(pin_out),
    .chan_pin_oe_n(oe_n), .timer_status_control(tsc), .channel_status_control(csc), .counter_value(cnt),
    .channel_compare_value(cval), .counter_modulus_value(cmod), .irq_request(irq));
  // Clock toggles every half period.
  always #2.5 clock = ~clock;
  // Prints the counts and the verdict, then stops the run.
  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // One cycle of stimulus: k selects the byte strobe (7 means none), rd the flag reads.
  task automatic wr(input int k, input logic [7:0] d, input logic [1:0] rd = 2'b00);
    byte_write_t b;
    b = '0;
    b.data = d;
    case (k)
      0: b.timer_sc = 1'b1;
      1: b.mod_high = 1'b1;
      2: b.mod_low = 1'b1;
      3: b.chan_sc = 1'b1;
      4: b.val_high = 1'b1;
      5: b.val_low = 1'b1;
      6: b.count_clear = 1'b1;
      default: ;
    endcase
    bw = b;
    fr = rd;
    @(posedge clock);
    #1;
  endtask : wr
  // Model of the counter (kind 1 counts up and down) and the pin, checked every cycle of a run.
  always @(negedge clock) begin
    if (run) begin
      if (kd != 1 || !dn) ex = (pc == md) ? ((kd == 1) ? pc - 1 : 0) : pc + 1;
      else ex = (pc == 0) ? 1 : pc - 1;
      if (seen) `CHK("count", 16'(ex), cnt)
      if (pin_ok) `CHK("pin", mp, pin_out)
      if (seen) dn = (kd == 1) && (cnt < pc);
      if (cnt == vl) begin
        mp = (kd == 2) ? !mp : ((kd == 1) && dn);
        pin_ok = 1;
      end else if (kd == 0 && cnt == 0) begin
        mp = 1;
        pin_ok = 1;
      end
      pc = cnt;
      seen = 1;
    end
  end
  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial begin
    #20000;
    num_errors++;
    test_done();
  end
  // Main sequence: edge PWM at 0%, partial and 100% duty, then center PWM, then compare toggling.
  initial begin
    void'($urandom(73833));
    repeat (3) @(posedge clock);
    #1;
    reset = 0;
    `CHK("tsc", 8'h00, tsc)
    `CHK("csc", 8'h00, csc)
    `CHK("oe_n", 1'b1, oe_n)
    `CHK("irq", 1'b0, irq)
    for (int it = 0; it < 5; it++) begin
      kd = (it < 3) ? 0 : it - 2;
      csd = (kd == 2) ? 8'h54 : 8'h68;
      if (it == 4) begin
        // Reset between runs with the counter stopped, then a rising edge on the pin in capture mode.
        reset = 1;
        wr(7, 8'h00);
        reset = 0;
        old_md = 0;
        old_vl = 0;
        `CHK("pin_rst", 1'b0, pin_out)
        `CHK("oe_rst", 1'b1, oe_n)
        wr(3, 8'h04);
        pin_in = 1;
        repeat (4) wr(7, 8'h00);
        pin_in = 0;
        `CHK("cap_flag", 1'b1, csc[7])
      end
      md = $urandom_range(3, 12);
      vl = (it == 0) ? 0 : (it == 2) ? md + 1 : $urandom_range((kd == 2) ? 3 : 1, (kd == 1) ? md - 1 : md);
      // A main control write between the halves drops the pending byte.
      wr(1, 8'h5a);
      wr(0, 8'h00);
      wr(2, 8'(md));
      wr(7, 8'h00);
      `CHK("mod_drop", 16'(old_md), cmod)
      wr(1, 8'h00);
      wr(2, 8'(md));
      wr(7, 8'h00);
      `CHK("mod", 16'(md), cmod)
      // Edge PWM active high, or compare toggling, channel interrupt enabled.
      wr(3, csd);
      wr(4, 8'hff);
      wr(3, csd);
      wr(5, 8'hff);
      wr(7, 8'h00);
      `CHK("val_drop", 16'(old_vl), cval)
      wr(3, csd);
      wr(4, 8'(vl >> 8));
      wr(5, 8'(vl));
      wr(7, 8'h00);
      `CHK("val", 16'(vl), cval)
      wr(6, 8'h00);
      wr(0, (kd == 1) ? 8'h28 : 8'h08);
      wr(7, 8'h00);
      wr(7, 8'h00);
      seen = 0;
      pin_ok = (kd == 2);
      mp = 0;
      dn = 0;
      run = 1;
      repeat (4 * md + 12) wr(7, 8'h00);
      run = 0;
      `CHK("oe_n_run", 1'b0, oe_n)
      wr(0, 8'h00);
      wr(7, 8'h00);
      `CHK("wrap_flag", 1'b1, tsc[7])
      `CHK("chan_flag", (vl <= md), csc[7])
      `CHK("irq_set", (vl <= md), irq)
      // A zero write without a prior read leaves the flag set.
      wr(0, 8'h00);
      wr(7, 8'h00);
      `CHK("wrap_hold", 1'b1, tsc[7])
      wr(7, 8'h00, 2'b11);
      wr(0, 8'h00);
      wr(3, csd);
      wr(7, 8'h00);
      wr(7, 8'h00);
      `CHK("wrap_clr", 1'b0, tsc[7])
      `CHK("chan_clr", 1'b0, csc[7])
      `CHK("irq_clr", 1'b0, irq)
      old_md = md;
      old_vl = vl;
    end
    test_done();
  end
endmodule : timer_channel_compare_pwm_tb
